// >>> rxaf_filter.sv
`timescale 1ns/100ps
// Operation
// - No mode bits: perfect match for all.
// - Group-hash bit: physical perfect, multicast hashed.
// - Both hash bits: hash every destination.
// - Inverse: reject station address, accept others.
// - Promiscuous accepts every frame, broadcasts included.
// - Pass-all-multicast accepts all multicast except broadcasts under broadcast reject.
// - First received bit marks multicast destination.
// - Perfect match uses full 48-bit station address.
// - Upper six CRC bits index hash table.
// - Index top bit picks high/low hash word.
// - Failing frames never enter receive path.
// - Wake mode suspends reception, checks patterns only.
// - Wake hit sets status, drives irq/power event.
// - Clearing wake enable resumes normal reception in D0.
// - Four filters, address check plus CRC match.
// - Mask bit j selects byte offset plus j.
// - D1 forces wake detection; D0 follows enable.
// - Broadcast wake frames ignore broadcast reject.
// - Filter word order: masks, command, offsets, CRCs.
// - Command bit0 enables, bit3 picks multicast.
// - Programmed CRC-16 equal computed CRC means hit.
// - Offset is byte count from destination start.
module rxaf_filter
   import rxaf_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready,
   input wire logic accept_all_frames,
   input wire logic pass_all_multicast,
   input wire logic inverse_address_match,
   input wire logic hash_for_all_destinations,
   input wire logic hash_for_group_destinations,
   input wire logic broadcast_reject,
   input wire logic [15:0] station_addr_hi,
   input wire logic [31:0] station_addr_lo,
   input wire logic [31:0] hash_table_hi,
   input wire logic [31:0] hash_table_lo,
   input wire logic wake_frame_filter_we,
   input wire logic [31:0] wake_frame_filter_port,
   input wire logic wake_pattern_enable,
   input wire logic power_state_d1,
   input wire logic wake_irq_enable,
   input wire logic wake_event_enable,
   input wire logic wake_seen_clear,
   output logic wake_pattern_seen,
   output logic host_irq,
   output logic power_event_output,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   input wire logic out_ready
);
   typedef enum logic [1:0] {ST_ADDR, ST_DRAIN, ST_PASS, ST_DROP}
      rxaf_st_t;
   typedef struct packed {
      rxaf_st_t st;
      logic [8:0] idx;
      logic [47:0] da;
      logic [31:0] crc;
      logic [2:0] dcnt;
      logic tail;
      logic rdy;
      logic [2:0] wp;
      logic [7:0][31:0] wff;
      logic chk;
      logic seen;
      logic irq;
      logic pev;
   } rxaf_state_t;
   localparam logic [4:0] LVL_SAFE = 5'(FIFO_DEPTH - 1);
   localparam logic [2:0] DA_LAST = 3'(DA_BYTES - 1);

   rxaf_state_t s_q, s_d;
   rxaf_byte_if feed ();
   logic take, wake_on, decide, acc;
   logic is_mc, is_bc, perfect, hash_hit, wake_hit;
   logic [47:0] da_n, station;
   logic [63:0] hash_tbl;
   logic [31:0] crc_n;
   logic [NUM_WAKE-1:0] hit, type_ok;
   logic fifo_push, fifo_rdy;
   logic [FIFO_W-1:0] fifo_din, fifo_dout;
   logic [4:0] fifo_lvl;

   assign take = rx_valid && s_q.rdy;
   // A level, so dropping the enable takes effect at the next frame
   assign wake_on = wake_pattern_enable || power_state_d1;
   assign da_n = {rx_data, s_q.da[47:8]};
   assign crc_n = crc32_byte(s_q.crc, rx_data);
   assign station = {station_addr_hi, station_addr_lo};
   assign hash_tbl = {hash_table_hi, hash_table_lo};
   assign is_mc = da_n[MCAST_BIT];
   assign is_bc = &da_n;
   assign perfect = da_n == station;
   assign hash_hit = hash_tbl[crc_n[31:HASH_LSB]];
   assign decide = take && s_q.st == ST_ADDR
      && s_q.idx == 9'(DA_LAST);

   always_comb begin
      if (accept_all_frames) begin
         acc = 1'b1;
      end else if (is_bc && broadcast_reject) begin
         acc = 1'b0;
      end else if (pass_all_multicast && is_mc) begin
         acc = 1'b1;
      end else if (inverse_address_match) begin
         acc = !perfect;
      end else if (hash_for_all_destinations
                   && hash_for_group_destinations) begin
         acc = hash_hit;
      end else if (hash_for_group_destinations && is_mc) begin
         acc = hash_hit;
      end else begin
         acc = perfect;
      end
   end

   assign feed.valid = take;
   assign feed.data = rx_data;
   assign feed.idx = s_q.idx;

   genvar i;
   generate
      for (i = 0; i < NUM_WAKE; i++) begin : g_wake
         rxaf_wake_filter i_rxaf_wake_filter (
            .clk(clk),
            .reset_n(reset_n),
            .bus(feed),
            .mask(s_q.wff[i][MASK_LEN-1:0]),
            .offset(s_q.wff[WFF_OFF_WORD][8*i +: 8]),
            .pattern(s_q.wff[WFF_CRC_WORD + 3'(i/2)][16*(i%2) +: 16]),
            .hit(hit[i])
         );
         // Broadcast reject plays no part here
         assign type_ok[i] = s_q.wff[WFF_CMD_WORD][8*i + CMD_MCAST_BIT]
            ? s_q.da[MCAST_BIT] : (s_q.da == station);
      end
   endgenerate

   always_comb begin
      wake_hit = 1'b0;
      for (int k = 0; k < NUM_WAKE; k++) begin
         if (s_q.wff[WFF_CMD_WORD][8*k + CMD_EN_BIT] && type_ok[k]
             && hit[k]) begin
            wake_hit = 1'b1;
         end
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.chk = 1'b0;
      fifo_push = 1'b0;
      fifo_din = '0;
      if (wake_frame_filter_we) begin
         s_d.wff[s_q.wp] = wake_frame_filter_port;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (take) begin
         s_d.idx = (s_q.idx == IDX_MAX) ? s_q.idx : s_q.idx + 1'b1;
         if (s_q.st == ST_ADDR) begin
            s_d.da = da_n;
            s_d.crc = crc_n;
         end
         if (s_q.st == ST_PASS) begin
            fifo_push = 1'b1;
            fifo_din = {rx_last, rx_data};
         end
         if (decide) begin
            // Wake mode never lets a frame through
            s_d.st = (acc && !wake_on) ? ST_DRAIN : ST_DROP;
            s_d.tail = rx_last;
         end
         if (rx_last) begin
            s_d.idx = '0;
            s_d.crc = CRC32_INIT;
            s_d.chk = wake_on;
            if (s_d.st != ST_DRAIN) begin
               s_d.st = ST_ADDR;
            end
         end
      end
      // Held address bytes go out first while the input is stalled
      if (s_q.st == ST_DRAIN && fifo_rdy) begin
         fifo_push = 1'b1;
         fifo_din = {s_q.tail && s_q.dcnt == DA_LAST,
                     s_q.da[8*s_q.dcnt +: 8]};
         s_d.dcnt = s_q.dcnt + 1'b1;
         if (s_q.dcnt == DA_LAST) begin
            s_d.dcnt = '0;
            s_d.st = s_q.tail ? ST_ADDR : ST_PASS;
         end
      end
      // Setting wins over a clear in the same cycle
      s_d.seen = (s_q.seen && !wake_seen_clear)
         || (s_q.chk && wake_hit);
      s_d.irq = s_d.seen && wake_irq_enable;
      s_d.pev = s_d.seen && wake_event_enable;
      // One free slot is kept because ready is a cycle late
      s_d.rdy = (s_d.st == ST_ADDR) || (s_d.st == ST_DROP)
         || (s_d.st == ST_PASS && fifo_lvl < LVL_SAFE);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '{st: ST_ADDR, crc: CRC32_INIT, rdy: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   rxaf_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) i_rxaf_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(fifo_push),
      .in_data(fifo_din),
      .in_ready(fifo_rdy),
      .level(fifo_lvl),
      .out_valid(out_valid),
      .out_data(fifo_dout),
      .out_ready(out_ready)
   );

   assign out_data = fifo_dout[7:0];
   assign out_last = fifo_dout[8];
   assign rx_ready = s_q.rdy;
   assign wake_pattern_seen = s_q.seen;
   assign host_irq = s_q.irq;
   assign power_event_output = s_q.pev;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic no_mode;
   assign no_mode = !(pass_all_multicast || accept_all_frames
      || inverse_address_match || hash_for_all_destinations
      || hash_for_group_destinations);

   chk_perfect_reject: assert property (decide && no_mode && !wake_on
      && !perfect |=> s_q.st == ST_DROP)
      else $error("perfect mode passed foreign address");
   chk_perfect_accept: assert property (decide && no_mode && !wake_on
      && perfect && !(is_bc && broadcast_reject)
      |=> s_q.st == ST_DRAIN ##1 !rx_ready)
      else $error("perfect match not received");
   chk_hash_select: assert property (decide |-> hash_hit ==
      (crc_n[31] ? hash_table_hi[crc_n[30:26]]
                 : hash_table_lo[crc_n[30:26]]))
      else $error("hash index selects wrong bit");
   chk_group_hash: assert property (decide && !wake_on
      && hash_for_group_destinations && !hash_for_all_destinations
      && !accept_all_frames && !pass_all_multicast
      && !inverse_address_match && !is_mc
      |=> s_q.st == ($past(perfect) ? ST_DRAIN : ST_DROP))
      else $error("physical address not perfect matched");
   chk_hash_all: assert property (decide && !wake_on && !hash_hit
      && hash_for_all_destinations && hash_for_group_destinations
      && !accept_all_frames && !inverse_address_match
      && !(pass_all_multicast && is_mc) |=> s_q.st == ST_DROP)
      else $error("hash miss accepted");
   chk_inverse: assert property (decide && !wake_on && perfect
      && inverse_address_match && !accept_all_frames
      && !pass_all_multicast |=> s_q.st == ST_DROP)
      else $error("inverse mode took station address");
   chk_promisc: assert property (decide && !wake_on
      && accept_all_frames |=> s_q.st == ST_DRAIN)
      else $error("promiscuous frame dropped");
   chk_mcast_pass: assert property (decide && !wake_on && is_mc
      && pass_all_multicast && !broadcast_reject
      |=> s_q.st == ST_DRAIN)
      else $error("multicast not passed");
   chk_wake_suspend: assert property (decide && wake_on
      |=> s_q.st == ST_DROP)
      else $error("frame received in wake mode");
   chk_drop_silent: assert property (s_q.st == ST_DROP
      |-> !fifo_push)
      else $error("rejected frame reached fifo");
   chk_seen_set: assert property (s_q.chk && wake_hit |=> s_q.seen
      && host_irq == $past(wake_irq_enable)
      && power_event_output == $past(wake_event_enable))
      else $error("wake hit not flagged");
   chk_seen_hold: assert property (s_q.seen && !wake_seen_clear
      |=> s_q.seen)
      else $error("wake status lost");
   chk_wff_wrap: assert property (wake_frame_filter_we
      && s_q.wp == 3'h7 |=> s_q.wp == 3'h0)
      else $error("filter word pointer did not wrap");
   cov_accept: cover property (decide && acc && !wake_on);
   cov_wake_hit: cover property (s_q.chk && wake_hit);
   cov_stall: cover property (s_q.st == ST_PASS && !s_q.rdy);
endmodule

// >>> rxaf_pkg.sv
package rxaf_pkg;
   localparam int DA_BYTES = 6;
   localparam logic [8:0] IDX_MAX = 9'h1FF;
   localparam int NUM_WAKE = 4;
   localparam int MASK_LEN = 31;
   localparam logic [2:0] WFF_CMD_WORD = 3'h4;
   localparam logic [2:0] WFF_OFF_WORD = 3'h5;
   localparam logic [2:0] WFF_CRC_WORD = 3'h6;
   localparam int CMD_EN_BIT = 0;
   localparam int CMD_MCAST_BIT = 3;
   localparam int MCAST_BIT = 0;
   localparam int HASH_LSB = 26;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 9;
   localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC32_POLY = 32'hEDB88320;
   localparam logic [15:0] CRC16_INIT = 16'hFFFF;
   localparam logic [15:0] CRC16_POLY = 16'hA001;

   // Both CRCs shift LSB first, as bits leave the wire
   function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                              input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC32_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                              input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// >>> rxaf_byte_if.sv
`timescale 1ns/100ps
interface rxaf_byte_if;
   logic valid;
   logic [7:0] data;
   logic [8:0] idx;
   modport src (output valid, data, idx);
   modport snk (input valid, data, idx);
endinterface

// >>> rxaf_fifo.sv
`timescale 1ns/100ps
module rxaf_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic [$clog2(DEPTH):0] level,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic irdy;
      logic ov;
      logic [W-1:0] od;
   } rxaf_fifo_state_t;
   localparam rxaf_fifo_state_t RST = '{irdy: 1'b1, default: '0};
   rxaf_fifo_state_t s_q, s_d;
   logic push, pop;

   always_comb begin
      s_d = s_q;
      push = in_valid && s_q.irdy;
      pop = (s_q.cnt != '0) && (!s_q.ov || out_ready);
      if (out_ready) begin
         s_d.ov = 1'b0;
      end
      if (pop) begin
         s_d.od = s_q.mem[s_q.rp];
         s_d.ov = 1'b1;
         s_d.rp = s_q.rp + 1'b1;
      end
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // Registered ready stays exact: a pop can only add room
      s_d.irdy = s_d.cnt < FULL;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready = s_q.irdy;
   assign level = s_q.cnt;
   assign out_valid = s_q.ov;
   assign out_data = s_q.od;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_fifo_full_stall: assert property (s_q.cnt == FULL |-> !in_ready)
      else $error("fifo ready while full");
   chk_fifo_out_hold: assert property (out_valid && !out_ready
      |=> out_valid && $stable(out_data))
      else $error("fifo output dropped under stall");
   cov_fifo_full: cover property (s_q.cnt == FULL);
endmodule

// >>> rxaf_wake_filter.sv
`timescale 1ns/100ps
module rxaf_wake_filter
   import rxaf_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   rxaf_byte_if.snk bus,
   input wire logic [MASK_LEN-1:0] mask,
   input wire logic [7:0] offset,
   input wire logic [15:0] pattern,
   output logic hit
);
   typedef struct packed {
      logic [15:0] crc;
   } rxaf_wf_state_t;
   rxaf_wf_state_t s_q, s_d;
   logic [8:0] rel;
   logic [15:0] base;
   logic in_win;

   always_comb begin
      s_d = s_q;
      rel = bus.idx - {1'b0, offset};
      in_win = (bus.idx >= {1'b0, offset}) && (rel < 9'(MASK_LEN))
         && mask[rel[4:0]];
      base = (bus.idx == '0) ? CRC16_INIT : s_q.crc;
      if (bus.valid) begin
         s_d.crc = in_win ? crc16_byte(base, bus.data) : base;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '{crc: CRC16_INIT};
      end else begin
         s_q <= s_d;
      end
   end

   assign hit = s_q.crc == pattern;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_crc_skip_byte: assert property (bus.valid && !in_win
      && bus.idx != '0 |=> $stable(s_q.crc))
      else $error("unmasked byte entered crc");
   chk_crc_restart: assert property (bus.valid && bus.idx == '0
      && !in_win |=> s_q.crc == CRC16_INIT)
      else $error("crc not restarted at frame start");
endmodule

// >>> rxaf_phy_model.sv
`timescale 1ns/100ps
module rxaf_phy_model (
   input wire logic clk,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last
);
   logic [7:0] mem [0:63];
   logic rdy_s;
   int gap = 0;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
   end

   // Ready is registered, so its value at an edge is the one seen at the
   // falling edge before it
   always @(negedge clk) begin
      rdy_s <= rx_ready;
   end

   // Bytes leave in wire order; gaps put junk on the idle data lines so a
   // stale byte is never mistaken for a fresh one
   task automatic send(input int len);
      for (int i = 0; i < len; i++) begin
         rx_valid <= 1'b1;
         rx_data <= mem[i];
         rx_last <= (i == len - 1);
         @(posedge clk);
         while (rdy_s !== 1'b1) begin
            @(posedge clk);
         end
         if (gap > 0) begin
            rx_valid <= 1'b0;
            rx_data <= ~mem[i];
            rx_last <= 1'b0;
            repeat (gap) @(posedge clk);
         end
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~mem[len - 1];
   endtask
endmodule

// >>> rxaf_filter_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) check_eq(64'(g), 64'(e))
module rxaf_filter_bench;
   import rxaf_pkg::*;
   localparam logic [47:0] ST = 48'hAB89_6745_2302;
   localparam logic [47:0] OTH = 48'hAB89_6745_2304;
   localparam logic [47:0] MC = 48'h0000_5E00_0001;
   localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] mode = 6'h00;
   logic [63:0] hash = 64'h0;
   logic we = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wen = 1'b0, d1 = 1'b0, irq_en = 1'b0, pev_en = 1'b0, clr = 1'b0;
   logic out_ready = 1'b1;
   logic rx_valid, rx_last, rx_ready, seen, irq, pev, out_valid, out_last;
   logic [7:0] rx_data, out_data;
   logic [8:0] cap [$];
   int mismatches = 0;
   int n_checks = 0;

   always #2.5 clk = ~clk;

   rxaf_phy_model i_rxaf_phy_model (.clk(clk), .rx_ready(rx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

   rxaf_filter i_rxaf_filter (
      .clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_ready(rx_ready),
      .accept_all_frames(mode[5]), .pass_all_multicast(mode[4]),
      .inverse_address_match(mode[3]), .hash_for_all_destinations(mode[2]),
      .hash_for_group_destinations(mode[1]), .broadcast_reject(mode[0]),
      .station_addr_hi(ST[47:32]), .station_addr_lo(ST[31:0]),
      .hash_table_hi(hash[63:32]), .hash_table_lo(hash[31:0]),
      .wake_frame_filter_we(we), .wake_frame_filter_port(wdata),
      .wake_pattern_enable(wen), .power_state_d1(d1),
      .wake_irq_enable(irq_en), .wake_event_enable(pev_en),
      .wake_seen_clear(clr), .wake_pattern_seen(seen), .host_irq(irq),
      .power_event_output(pev), .out_valid(out_valid), .out_data(out_data),
      .out_last(out_last), .out_ready(out_ready));

   always @(posedge clk) begin
      if (reset_n && out_valid && out_ready) begin
         cap.push_back({out_last, out_data});
      end
   end

   task automatic check_eq(input logic [63:0] g, input logic [63:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Independent reflected CRC, no final inversion; 16-bit use keeps the
   // upper half zero
   function automatic logic [31:0] crc_r(input logic [31:0] c,
         input logic [31:0] p, input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ b[i]) ? ((c >> 1) ^ p) : (c >> 1);
      end
      return c;
   endfunction

   task automatic frame(input logic [47:0] da, input int len);
      for (int i = 0; i < len; i++) begin
         i_rxaf_phy_model.mem[i] = (i < DA_BYTES) ? da[8*i +: 8]
                                                  : 8'(3 * i + 1);
      end
   endtask

   task automatic judge(input int n);
      `CHK(cap.size(), n);
      foreach (cap[i]) begin
         `CHK(cap[i], {i == n - 1, i_rxaf_phy_model.mem[i]});
      end
   endtask

   task automatic run(input logic [47:0] da, input int len, input bit acc);
      frame(da, len);
      cap.delete();
      @(posedge clk);
      i_rxaf_phy_model.send(len);
      repeat (len + 20) @(posedge clk);
      judge(acc ? len : 0);
   endtask

   // One table bit only, or every bit but that one
   task automatic set_hash(input logic [47:0] da, input bit hit);
      logic [31:0] c;
      c = CRC32_INIT;
      for (int k = 0; k < DA_BYTES; k++) begin
         c = crc_r(c, CRC32_POLY, da[8*k +: 8]);
      end
      hash <= hit ? (64'h1 << c[31:26]) : ~(64'h1 << c[31:26]);
   endtask

   task automatic wake_try(input bit hit);
      cap.delete();
      @(posedge clk);
      i_rxaf_phy_model.send(30);
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(seen, hit);
      `CHK(cap.size(), 0);
      // Hand back on a rising edge so callers drive inputs there
      @(posedge clk);
   endtask

   task automatic t_perfect;
      mode <= 6'h00;
      run(ST, 20, 1);
      run(ST ^ 48'h8000_0000_0000, 20, 0);
      run(MC, 20, 0);
      // Address-only frame ends inside the drain; runt never decides
      run(ST, 6, 1);
      run(ST, 4, 0);
      $display("test perfect done");
   endtask

   task automatic t_hash;
      mode <= 6'h02;
      set_hash(MC, 1);
      run(MC, 20, 1);
      set_hash(MC, 0);
      run(MC, 20, 0);
      run(ST, 20, 1);
      mode <= 6'h06;
      set_hash(OTH, 1);
      run(OTH, 20, 1);
      set_hash(OTH, 0);
      run(OTH, 20, 0);
      $display("test hash done");
   endtask

   task automatic t_inverse;
      mode <= 6'h08;
      i_rxaf_phy_model.gap = 2;
      run(ST, 20, 0);
      run(OTH, 20, 1);
      i_rxaf_phy_model.gap = 0;
      $display("test inverse done");
   endtask

   task automatic t_promisc;
      mode <= 6'h27;
      set_hash(BC, 0);
      run(BC, 20, 1);
      run(OTH, 20, 1);
      $display("test promiscuous done");
   endtask

   task automatic t_mcast;
      mode <= 6'h10;
      run(MC, 20, 1);
      run(OTH, 20, 0);
      mode <= 6'h16;
      set_hash(OTH, 1);
      run(OTH, 20, 1);
      set_hash(MC, 0);
      run(MC, 20, 1);
      mode <= 6'h11;
      run(BC, 20, 0);
      run(MC, 20, 1);
      $display("test multicast pass done");
   endtask

   task automatic t_fifo;
      mode <= 6'h00;
      frame(ST, 40);
      cap.delete();
      @(posedge clk);
      out_ready <= 1'b0;
      fork
         i_rxaf_phy_model.send(40);
         begin
            repeat (40) @(posedge clk);
            @(negedge clk);
            `CHK(rx_ready, 0);
            `CHK(cap.size(), 0);
            @(posedge clk);
            out_ready <= 1'b1;
         end
      join
      repeat (30) @(posedge clk);
      judge(40);
      $display("test buffer done");
   endtask

   task automatic t_wake;
      logic [31:0] c;
      logic [31:0] w [8];
      mode <= 6'h00;
      frame(ST, 30);
      c = {16'h0, CRC16_INIT};
      c = crc_r(c, {16'h0, CRC16_POLY}, i_rxaf_phy_model.mem[14]);
      c = crc_r(c, {16'h0, CRC16_POLY}, i_rxaf_phy_model.mem[16]);
      // Filter 0 unicast, filter 1 multicast, both on bytes 14 and 16
      w = '{32'h5, 32'h5, 32'h0, 32'h0, 32'h901, 32'hE0E,
            {c[15:0], c[15:0]}, 32'h0};
      for (int k = 0; k < 8; k++) begin
         we <= 1'b1;
         wdata <= w[k];
         @(posedge clk);
      end
      we <= 1'b0;
      wen <= 1'b1;
      irq_en <= 1'b1;
      i_rxaf_phy_model.mem[16] ^= 8'h01;
      wake_try(0);
      frame(ST, 30);
      i_rxaf_phy_model.mem[15] ^= 8'hFF;
      wake_try(1);
      `CHK(irq, 1);
      `CHK(pev, 0);
      clr <= 1'b1;
      wen <= 1'b0;
      @(posedge clk);
      clr <= 1'b0;
      run(ST, 20, 1);
      `CHK(seen, 0);
      `CHK(irq, 0);
      d1 <= 1'b1;
      pev_en <= 1'b1;
      mode <= 6'h01;
      frame(OTH, 30);
      wake_try(0);
      frame(BC, 30);
      wake_try(1);
      `CHK(pev, 1);
      d1 <= 1'b0;
      $display("test wake done");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_perfect();
      t_hash();
      t_inverse();
      t_promisc();
      t_mcast();
      t_fifo();
      t_wake();
      tally_and_finish();
   end

   // Whole run needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
endmodule
